// [safe_torque_off_monitor_bench.sv]
`timescale 1ns/1ps
`include "stom_map.vh"

// =====================================================================
// Bench
module safe_torque_off_monitor_bench;
  localparam int DLY = 20;
  logic clk = 0, rst_n = 0, son = 0, dflt = 0, wr = 0, rd = 0;
  logic [1:0] dia = 2'b11;
  logic [2:0] cmd = 3'b000;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d;
  logic sa, sb, breq, rdy, run, bst, so, dmon, irq;
  logic [5:0] gate;
  int bad_count = 0, tests_run = 0, cyc = 0;

  always #2.5 clk = ~clk;

  stom_ctrl_model i_ctl (.clk_i(clk), .cmd_i(cmd), .pin_a_o(sa), .pin_b_o(sb), .bus_req_o(breq));

  stom_top #(.READY_DELAY_CYC(DLY)) i_dut (
    .sys_clk_i(clk), .arst_n_i(rst_n), .clk_en_i(1'b1),
    .safe_off_input_a_i(sa), .safe_off_input_b_i(sb),
    .safety_digital_input_a_i(dia), .safety_digital_input_b_i(2'b11),
    .bus_torque_off_req_i(breq), .servo_on_cmd_i(son), .dangerous_fault_i(dflt),
    .pwm_i(6'h2a), .reg_addr_i(adr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .gate_pwm_o(gate), .servo_ready_o(rdy), .servo_run_o(run),
    .bus_torque_off_state_o(bst), .safety_status_output_one_o(so),
    .external_device_monitor_output_o(dmon), .irq_o(irq));

  // =====================================================================
  // Shared tasks
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chkw(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Ends 1 ns past an edge so outputs have settled
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task drv(input logic [2:0] c, input logic s, input logic f, input logic [1:0] a);
    @(posedge clk);
    cmd <= c;
    son <= s;
    dflt <= f;
    dia <= a;
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    adr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask

  task recover;
    drv(3'b011, 1'b0, 1'b0, 2'b11);
    w(40);
    chkw("ready", 32'h1, {31'h0, rdy});
  endtask

  // =====================================================================
  // Scenarios
  task t_regs;
    rd_reg(`STOM_REG_CTRL);
    chkw("ctrl", `STOM_CTRL_RST, d);
    rd_reg(`STOM_REG_DISC_TIME);
    chkw("disc_time", `STOM_DISC_TIME_RST, d);
    rd_reg(`STOM_REG_IRQ_MASK);
    chkw("irq_mask", 32'h0, d);
    rd_reg(8'h20);
    chkw("unmapped", 32'h0, d);
  endtask

  task t_start;
    drv(3'b011, 1'b1, 1'b0, 2'b11);
    w(40);
    chkw("ready son", 32'h0, {31'h0, rdy});
    drv(3'b011, 1'b0, 1'b1, 2'b11);
    w(40);
    chkw("ready flt", 32'h0, {31'h0, rdy});
    drv(3'b011, 1'b0, 1'b0, 2'b11);
    w(DLY - 6);
    chkw("ready early", 32'h0, {31'h0, rdy});
    chkw("gate early", 32'h0, {26'h0, gate});
    w(20);
    chkw("ready late", 32'h1, {31'h0, rdy});
    chkw("gate run", 32'h2a, {26'h0, gate});
    drv(3'b011, 1'b1, 1'b0, 2'b11);
    w(3);
    chkw("run", 32'h1, {31'h0, run});
  endtask

  task t_drop;
    wr_reg(`STOM_REG_IRQ_MASK, 32'h1);
    drv(3'b010, 1'b0, 1'b0, 2'b11);
    w(8);
    chkw("gate a low", 32'h0, {26'h0, gate});
    chkw("monitor one low", 32'h0, {31'h0, dmon});
    chkw("irq set", 32'h1, {31'h0, irq});
    drv(3'b000, 1'b0, 1'b0, 2'b11);
    w(8);
    chkw("monitor both low", 32'h1, {31'h0, dmon});
    wr_reg(`STOM_REG_IRQ_STAT, 32'hf);
    w(2);
    chkw("irq clear", 32'h0, {31'h0, irq});
    wr_reg(`STOM_REG_IRQ_MASK, 32'h0);
    recover();
    // Channel b alone must block gating as well
    drv(3'b001, 1'b0, 1'b0, 2'b11);
    w(8);
    chkw("gate b low", 32'h0, {26'h0, gate});
    chkw("monitor b low", 32'h0, {31'h0, dmon});
    recover();
  endtask

  task t_bus;
    wr_reg(`STOM_REG_CTRL, 32'h1);
    drv(3'b111, 1'b0, 1'b0, 2'b11);
    w(8);
    chkw("bus safe", 32'h1, {31'h0, bst});
    drv(3'b011, 1'b0, 1'b0, 2'b11);
    w(40);
    chkw("bus left", 32'h0, {31'h0, bst});
    wr_reg(`STOM_REG_CTRL, 32'h0);
    drv(3'b111, 1'b0, 1'b0, 2'b11);
    w(8);
    chkw("bus ignored", 32'h0, {31'h0, bst});
  endtask

  task t_local;
    wr_reg(`STOM_REG_DI_FUNC, 32'h1);
    wr_reg(`STOM_REG_DO_FUNC, 32'h1);
    wr_reg(`STOM_REG_DISC_TIME, 32'h5);
    recover();
    drv(3'b011, 1'b0, 1'b0, 2'b10);
    w(3);
    rd_reg(`STOM_REG_STATUS);
    chkw("disc early", 32'h0, {31'h0, d[16]});
    w(8);
    chkw("status out", 32'h1, {31'h0, so});
    rd_reg(`STOM_REG_STATUS);
    chkw("disc fault", 32'h1, {31'h0, d[16]});
    drv(3'b011, 1'b0, 1'b0, 2'b11);
    w(40);
    chkw("status off", 32'h0, {31'h0, so});
    rd_reg(`STOM_REG_STATUS);
    chkw("disc gone", 32'h0, {31'h0, d[16]});
  endtask

  // =====================================================================
  // Hang guard, then main sequence
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      conclude();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_start();
    t_drop();
    t_bus();
    t_local();
    conclude();
  end
endmodule

// [stom_checker_assertions.sv]
`timescale 1ns/1ps

// =====================================================================
// Port checker
module stom_checker #(
  parameter PWM_W = 6
)(
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire safe_off_input_a_i,
  input wire safe_off_input_b_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  input wire [PWM_W-1:0] gate_pwm_o,
  input wire servo_ready_o,
  input wire servo_run_o,
  input wire bus_torque_off_state_o,
  input wire safety_status_output_one_o,
  input wire external_device_monitor_output_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  // Five samples cover two sync flops, the request flop and the gating flop, and the sample that sees it
  gate_block_a: assert property (!safe_off_input_a_i [*5] |-> gate_pwm_o == 0)
    else $error("gating seen with input a low");
  gate_b_block_a: assert property (!safe_off_input_b_i [*5] |-> gate_pwm_o == 0)
    else $error("gating seen with input b low");
  monitor_on_a: assert property ((!safe_off_input_a_i && !safe_off_input_b_i) [*4]
    |-> external_device_monitor_output_o) else $error("monitor low with both inputs low");
  monitor_off_a: assert property (safe_off_input_a_i [*4]
    |-> !external_device_monitor_output_o) else $error("monitor high with input a high");
  ready_not_safe_a: assert property (servo_ready_o |-> !bus_torque_off_state_o)
    else $error("ready while in safe state");
  run_needs_ready_a: assert property (servo_run_o |-> servo_ready_o)
    else $error("run without ready");
  stat_out_safe_a: assert property (safety_status_output_one_o |-> bus_torque_off_state_o)
    else $error("status output outside safe state");
  ready_pins_high_a: assert property ($rose(servo_ready_o)
    |-> $past(safe_off_input_a_i, 4) && $past(safe_off_input_b_i, 4))
    else $error("ready rose with a pin low");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h00000000)
    else $error("read data outside read slot");
endmodule

bind stom_top stom_checker #(.PWM_W(PWM_W)) i_chk (
  .sys_clk_i(sys_clk_i),
  .arst_n_i(arst_n_i),
  .safe_off_input_a_i(safe_off_input_a_i),
  .safe_off_input_b_i(safe_off_input_b_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .gate_pwm_o(gate_pwm_o),
  .servo_ready_o(servo_ready_o),
  .servo_run_o(servo_run_o),
  .bus_torque_off_state_o(bus_torque_off_state_o),
  .safety_status_output_one_o(safety_status_output_one_o),
  .external_device_monitor_output_o(external_device_monitor_output_o)
);

// [stom_ctrl_model.sv]
`timescale 1ns/1ps

// =====================================================================
// Far-side safety controller: wired pair plus bus request
module stom_ctrl_model (
  input wire logic clk_i,
  input wire logic [2:0] cmd_i,
  output logic pin_a_o,
  output logic pin_b_o,
  output logic bus_req_o
);
  // Registered so every change leaves just after an edge, as a real relay would not
  initial {bus_req_o, pin_b_o, pin_a_o} = 3'b000;
  always @(posedge clk_i)
  begin
    {bus_req_o, pin_b_o, pin_a_o} <= cmd_i;
  end
endmodule

// [stom_disc_mon.v]
`timescale 1ns/1ps
`include "stom_map.vh"

// =====================================================================
// Dual-channel monitor: request on either channel low, discrepancy timer
module stom_disc_mon #(
  parameter DISC_W = 32
)(
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire clk_en_i,
  input wire chan_a_i,
  input wire chan_b_i,
  input wire [DISC_W-1:0] limit_i,
  output reg req_o,
  output reg fault_o
);

  reg [DISC_W-1:0] disc_cnt;

  // Channels are synchronised by the caller; either low is a request
  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      req_o <= 1'b1;
      fault_o <= 1'b0;
      disc_cnt <= {DISC_W{1'b0}};
    end
    else if (clk_en_i)
    begin
      req_o <= ~(chan_a_i & chan_b_i);
      if (chan_a_i == chan_b_i)
      begin
        // Agreement restarts the allowed window and clears the fault
        disc_cnt <= {DISC_W{1'b0}};
        fault_o <= 1'b0;
      end
      else if (disc_cnt >= limit_i)
        fault_o <= 1'b1;
      else
        disc_cnt <= disc_cnt + {{(DISC_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// [stom_map.vh]
`ifndef STOM_MAP_VH
`define STOM_MAP_VH

// =====================================================================
// Register offsets (byte addresses on the plain register port)
`define STOM_REG_CTRL 8'h00
`define STOM_REG_DI_FUNC 8'h04
`define STOM_REG_DO_FUNC 8'h08
`define STOM_REG_DISC_TIME 8'h0c
`define STOM_REG_STATUS 8'h10
`define STOM_REG_IRQ_STAT 8'h14
`define STOM_REG_IRQ_MASK 8'h18

// =====================================================================
// Field positions and widths
`define STOM_CTRL_TRIG_SRC 0
`define STOM_FUNC_W 4
`define STOM_ST_SAFE 0
`define STOM_ST_MON_OUT 1
`define STOM_ST_PAIR_A 2
`define STOM_ST_PAIR_B 3
`define STOM_ST_READY 4
`define STOM_ST_HW_DISC 5
`define STOM_ST_FSM_LSB 6
`define STOM_ST_DI_REQ_LSB 8
`define STOM_ST_DI_DISC_LSB 16
`define STOM_IRQ_W 4
`define STOM_IRQ_SAFE_IN 0
`define STOM_IRQ_SAFE_OUT 1
`define STOM_IRQ_HW_DISC 2
`define STOM_IRQ_DI_DISC 3

// =====================================================================
// Codes and reset values
`define STOM_FUNC_TORQUE_OFF 4'h1
`define STOM_TRIG_LOCAL 1'b0
`define STOM_TRIG_BUS 1'b1
`define STOM_CTRL_RST 32'h00000000
`define STOM_DI_FUNC_RST 32'h00000000
`define STOM_DO_FUNC_RST 32'h00000000
`define STOM_DISC_TIME_RST 32'h000f4240
`define STOM_IRQ_MASK_RST 4'h0

// =====================================================================
// Timing
`define STOM_CLK_MHZ 200
`define STOM_RESP_TYP_MS 30
`define STOM_RESP_MAX_MS 100
`define STOM_READY_DELAY_MS 400
`define STOM_READY_DELAY_CYC (`STOM_READY_DELAY_MS * `STOM_CLK_MHZ * 1000)

`endif

// [stom_top.v]
// Contract
// - Gating may run only while both redundant safe-off inputs are energized.
// - Either safe-off input going low blocks gating, typically within 30 ms.
// - The time from a safe-off input going low to blocked gating never exceeds 100 ms.
// - Trigger source 0 takes safety requests from the local safety digital inputs.
// - Trigger source 1 takes safety requests from received fieldbus process data.
// - Each local safety input and output has a function code; code 1 means torque-off.
// - A status output assigned to torque-off is active while the device is in torque-off.
// - Each local safety input has channels A and B and either one requests the function.
// - Channel disagreement lasting beyond the allowed time raises that input's fault.
// - On the bus the controller sends the request and the device returns its safe state.
// - The safe state is left automatically once the request is gone, with no acknowledge.
// - Recovery needs inputs high, servo-on command inactive and no dangerous fault.
// - After recovery, ready and operation outputs stay low for 400 ms before rising.
// - The device monitor output is active only when both filtered inputs are low.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "stom_map.vh"

module stom_top #(
  parameter DI_NUM = 2,
  parameter PWM_W = 6,
  parameter DISC_W = 32,
  parameter READY_DELAY_CYC = `STOM_READY_DELAY_CYC
)(
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire clk_en_i,
  input wire safe_off_input_a_i,
  input wire safe_off_input_b_i,
  input wire [DI_NUM-1:0] safety_digital_input_a_i,
  input wire [DI_NUM-1:0] safety_digital_input_b_i,
  input wire bus_torque_off_req_i,
  input wire servo_on_cmd_i,
  input wire dangerous_fault_i,
  input wire [PWM_W-1:0] pwm_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  output reg [PWM_W-1:0] gate_pwm_o,
  output reg servo_ready_o,
  output reg servo_run_o,
  output reg bus_torque_off_state_o,
  output reg safety_status_output_one_o,
  output reg external_device_monitor_output_o,
  output reg irq_o
);

  // =====================================================================
  // Constants and helpers
  localparam PIN_W = 2 * DI_NUM + 2;
  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_SAFE = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;
  localparam [31:0] DELAY_LAST = READY_DELAY_CYC - 1;
  // Full-word reset values, cut to each register's own width where they are applied
  localparam [31:0] CTRL_RST = `STOM_CTRL_RST;
  localparam [31:0] DO_FUNC_RST = `STOM_DO_FUNC_RST;
  localparam [31:0] DISC_TIME_RST = `STOM_DISC_TIME_RST;

  // Decode of a function code, shared by the input and output assignments
  function is_torque_off;
    input [`STOM_FUNC_W-1:0] code;
    begin
      is_torque_off = (code == `STOM_FUNC_TORQUE_OFF);
    end
  endfunction

  // =====================================================================
  // Configuration and interrupt registers
  reg trig_src;
  reg [31:0] di_func;
  reg [`STOM_FUNC_W-1:0] do_func;
  reg [DISC_W-1:0] disc_time;
  reg [`STOM_IRQ_W-1:0] irq_stat;
  reg [`STOM_IRQ_W-1:0] irq_mask;
  reg [`STOM_IRQ_W-1:0] irq_set;
  reg [`STOM_IRQ_W-1:0] irq_clr;
  reg [`STOM_IRQ_W-1:0] next_irq_stat;

  // =====================================================================
  // Pin synchronisers
  wire [PIN_W-1:0] pin_raw;
  reg [PIN_W-1:0] pin_meta;
  reg [PIN_W-1:0] pin_sync;

  assign pin_raw = {safety_digital_input_b_i, safety_digital_input_a_i,
                    safe_off_input_b_i, safe_off_input_a_i};

  // Two flops per pin; the first stage is read only by the second
  genvar g;
  generate
    for (g = 0; g < PIN_W; g = g + 1)
    begin : g_sync
      always @(posedge sys_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          pin_meta[g] <= 1'b0;
          pin_sync[g] <= 1'b0;
        end
        else if (clk_en_i)
        begin
          pin_meta[g] <= pin_raw[g];
          pin_sync[g] <= pin_meta[g];
        end
      end
    end
  endgenerate

  wire pair_a = pin_sync[0];
  wire pair_b = pin_sync[1];
  wire [DI_NUM-1:0] di_a = pin_sync[DI_NUM+1:2];
  wire [DI_NUM-1:0] di_b = pin_sync[2*DI_NUM+1:DI_NUM+2];

  // Monitor inputs with the hard-wired pair on top, so no index runs past a local vector
  wire [DI_NUM:0] mon_a = {pair_a, di_a};
  wire [DI_NUM:0] mon_b = {pair_b, di_b};

  // =====================================================================
  // Channel monitors: one per local input, the last one for the safe-off pair
  wire [DI_NUM:0] chan_req;
  wire [DI_NUM:0] chan_fault;
  reg [DI_NUM:0] chan_fault_q;

  generate
    for (g = 0; g <= DI_NUM; g = g + 1)
    begin : g_mon
      stom_disc_mon #(
        .DISC_W(DISC_W)
      ) u_mon (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .clk_en_i(clk_en_i),
        .chan_a_i(mon_a[g]),
        .chan_b_i(mon_b[g]),
        .limit_i(disc_time),
        .req_o(chan_req[g]),
        .fault_o(chan_fault[g])
      );
    end
  endgenerate

  // =====================================================================
  // Request selection
  reg di_req;
  reg [DI_NUM-1:0] di_req_vec;
  wire sel_req;
  wire hw_req;
  wire any_req;
  integer i;

  // Only inputs assigned the torque-off code contribute
  always @*
  begin
    di_req_vec = {DI_NUM{1'b0}};
    for (i = 0; i < DI_NUM; i = i + 1)
      di_req_vec[i] = chan_req[i] & is_torque_off(di_func[i*4 +: 4]);
    di_req = |di_req_vec;
  end

  // Source of the selectable requests; the hard-wired pair always applies
  assign sel_req = (trig_src == `STOM_TRIG_BUS) ? bus_torque_off_req_i
                                                : di_req;
  assign hw_req = chan_req[DI_NUM];
  assign any_req = hw_req | sel_req;

  // =====================================================================
  // Safe-state sequencer
  reg [1:0] state;
  reg [1:0] next_state;
  reg [31:0] wait_cnt;
  reg [31:0] next_wait_cnt;
  wire recover_ok;

  // No acknowledge is involved in leaving the safe state
  assign recover_ok = ~any_req & ~servo_on_cmd_i & ~dangerous_fault_i;

  always @*
  begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    case (state)
      ST_RUN:
      begin
        // Blocking follows the request within a few clocks, far inside 100 ms
        if (any_req)
          next_state = ST_SAFE;
      end
      ST_SAFE:
      begin
        next_wait_cnt = 32'h00000000;
        if (recover_ok)
          next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        // A new request or fault during the hold-off drops back to safe
        if (any_req || dangerous_fault_i)
          next_state = ST_SAFE;
        else if (wait_cnt >= DELAY_LAST)
          next_state = ST_RUN;
        else
          next_wait_cnt = wait_cnt + 32'h00000001;
      end
      default:
        next_state = ST_SAFE;
    endcase
  end

  // Comes up safe: gating stays blocked until a clean recovery
  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= ST_SAFE;
      wait_cnt <= 32'h00000000;
    end
    else if (clk_en_i)
    begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
    end
  end

  // =====================================================================
  // Drive outputs, all registered
  wire next_safe = (next_state != ST_RUN);

  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      gate_pwm_o <= {PWM_W{1'b0}};
      servo_ready_o <= 1'b0;
      servo_run_o <= 1'b0;
      bus_torque_off_state_o <= 1'b1;
      safety_status_output_one_o <= 1'b0;
      external_device_monitor_output_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      gate_pwm_o <= next_safe ? {PWM_W{1'b0}} : pwm_i;
      servo_ready_o <= ~next_safe;
      servo_run_o <= ~next_safe & servo_on_cmd_i;
      bus_torque_off_state_o <= next_safe;
      safety_status_output_one_o <= is_torque_off(do_func) & next_safe;
      external_device_monitor_output_o <= ~pair_a & ~pair_b;
    end
  end

  // =====================================================================
  // Interrupt events
  always @*
  begin
    irq_set = {`STOM_IRQ_W{1'b0}};
    irq_set[`STOM_IRQ_SAFE_IN] = (state == ST_RUN) & next_safe;
    irq_set[`STOM_IRQ_SAFE_OUT] = (state != ST_RUN) & ~next_safe;
    irq_set[`STOM_IRQ_HW_DISC] = chan_fault[DI_NUM] & ~chan_fault_q[DI_NUM];
    irq_set[`STOM_IRQ_DI_DISC] = |(chan_fault[DI_NUM-1:0] & ~chan_fault_q[DI_NUM-1:0]);
    irq_clr = (reg_wr_i && reg_addr_i == `STOM_REG_IRQ_STAT) ?
              reg_wdata_i[`STOM_IRQ_W-1:0] : {`STOM_IRQ_W{1'b0}};
    // A new event wins over a clear in the same cycle
    next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
  end

  // =====================================================================
  // Register writes
  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      trig_src <= CTRL_RST[`STOM_CTRL_TRIG_SRC];
      di_func <= `STOM_DI_FUNC_RST;
      do_func <= DO_FUNC_RST[`STOM_FUNC_W-1:0];
      disc_time <= DISC_TIME_RST[DISC_W-1:0];
      irq_mask <= `STOM_IRQ_MASK_RST;
      irq_stat <= {`STOM_IRQ_W{1'b0}};
      chan_fault_q <= {(DI_NUM+1){1'b0}};
      irq_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      irq_stat <= next_irq_stat;
      chan_fault_q <= chan_fault;
      irq_o <= |(next_irq_stat & irq_mask);
      if (reg_wr_i)
      begin
        case (reg_addr_i)
          `STOM_REG_CTRL: trig_src <= reg_wdata_i[`STOM_CTRL_TRIG_SRC];
          `STOM_REG_DI_FUNC: di_func <= reg_wdata_i;
          `STOM_REG_DO_FUNC: do_func <= reg_wdata_i[`STOM_FUNC_W-1:0];
          `STOM_REG_DISC_TIME: disc_time <= reg_wdata_i[DISC_W-1:0];
          `STOM_REG_IRQ_MASK: irq_mask <= reg_wdata_i[`STOM_IRQ_W-1:0];
          default:
          begin
          end
        endcase
      end
    end
  end

  // =====================================================================
  // Register reads: data stand only in the cycle after the strobe
  reg [31:0] status_word;
  reg [31:0] rd_mux;

  always @*
  begin
    status_word = 32'h00000000;
    status_word[`STOM_ST_SAFE] = (state != ST_RUN);
    status_word[`STOM_ST_MON_OUT] = external_device_monitor_output_o;
    status_word[`STOM_ST_PAIR_A] = pair_a;
    status_word[`STOM_ST_PAIR_B] = pair_b;
    status_word[`STOM_ST_READY] = servo_ready_o;
    status_word[`STOM_ST_HW_DISC] = chan_fault[DI_NUM];
    status_word[`STOM_ST_FSM_LSB +: 2] = state;
    status_word[`STOM_ST_DI_REQ_LSB +: DI_NUM] = di_req_vec;
    status_word[`STOM_ST_DI_DISC_LSB +: DI_NUM] = chan_fault[DI_NUM-1:0];
    rd_mux = 32'h00000000;
    case (reg_addr_i)
      `STOM_REG_CTRL: rd_mux[`STOM_CTRL_TRIG_SRC] = trig_src;
      `STOM_REG_DI_FUNC: rd_mux = di_func;
      `STOM_REG_DO_FUNC: rd_mux[`STOM_FUNC_W-1:0] = do_func;
      `STOM_REG_DISC_TIME: rd_mux[DISC_W-1:0] = disc_time;
      `STOM_REG_STATUS: rd_mux = status_word;
      `STOM_REG_IRQ_STAT: rd_mux[`STOM_IRQ_W-1:0] = irq_stat;
      `STOM_REG_IRQ_MASK: rd_mux[`STOM_IRQ_W-1:0] = irq_mask;
      default: rd_mux = 32'h00000000; // Unmapped reads as zero
    endcase
  end

  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= 32'h00000000;
    else if (clk_en_i)
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h00000000;
  end

endmodule
